// File: verilog/cmo_pkg.sv
// Constants and types shared by the clock manager output block
package cmo_pkg;
  localparam int PERIOD_W = 16;
  localparam int STATUS_W = 16;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0000;
  localparam int ST_OVF = 0;
  localparam int ST_REF_STOP = 1;
  localparam int ST_SYNTH_STOP = 2;
  localparam int ST_FB_STOP = 3;
  // Register byte offsets on the Avalon slave
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PERIOD = 4'h8;
  localparam logic [3:0] REG_SHIFT = 4'hC;
  localparam int CTRL_RESTART_BIT = 0;
  localparam int STAT_LOCKED_BIT = 8;
  localparam int STAT_LOST_BIT = 9;
  // Counts
  localparam int LOCK_REF_CYCLES = 4096;
  localparam int FB_LOSS_CYCLES = 8192;
  localparam logic [31:0] SYNTH_STOP_CYCLES = 32'h0000_0100;
  localparam logic [3:0] SHIFT_STEP_CYCLES = 4'h4;
  localparam logic signed [9:0] SHIFT_LIMIT = 10'sh0FF;
  localparam int DIVISION_DEFAULT = 2;
  localparam int SYNTH_MULT_DEFAULT = 4;
  localparam int SYNTH_DIV_DEFAULT = 1;
  typedef enum logic [2:0] {
    SHIFT_NONE, SHIFT_FIXED, SHIFT_VAR_POS, SHIFT_VAR_CENTER, SHIFT_DIRECT
  } cmo_shift_mode_t;
  typedef enum logic [1:0] {LK_ACQUIRE, LK_LOCKED, LK_LOST} cmo_lock_state_t;
endpackage

// File: verilog/cmo_sync.sv
// Two-flop synchroniser with edge pulses taken after the second flop
module cmo_sync (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level_q,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic prev_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_q  <= 1'b0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      meta_q  <= async_in;
      level_q <= meta_q;
      prev_q  <= level_q;
    end
  end

  assign rise = level_q & ~prev_q;
  assign fall = ~level_q & prev_q;
endmodule

// File: verilog/cmo_stop_detect.sv
// Flags a signal that has shown no edge for longer than a limit
module cmo_stop_detect (
  input  wire logic        core_clk,
  input  wire logic        clear,
  input  wire logic        edge_seen,
  input  wire logic [31:0] limit,
  output logic             stopped_q
);
  logic [31:0] idle_q;

  always_ff @(posedge core_clk) begin
    if (clear) begin
      idle_q    <= 32'h0000_0000;
      stopped_q <= 1'b0;
    end else begin
      if (edge_seen) begin
        idle_q <= 32'h0000_0000;
      end else if (idle_q != 32'hFFFF_FFFF) begin
        idle_q <= idle_q + 32'h0000_0001;
      end
      // A single missed edge gives a gap equal to the limit, which is tolerated
      stopped_q <= !edge_seen && (idle_q > limit);
    end
  end
endmodule

// File: verilog/cmo_clock_manager.sv
// Clock manager outputs: derived clocks, lock, phase shift, status bus
// Function
// - Base output runs at effective reference rate
// - Quarter, half, three-quarter delayed 1x outputs
// - Locked doubled output, aligned, even duty
// - Before lock doubled is 1x, quarter high
// - Inverted doubled output half period shifted once locked; before lock it is high three quarters of the period
// - Divided output aligned, reference over setting
// - Synthesized rate is reference times M over D
// - Synth rising edges align every D cycles
// - Inverted synthesized output half period shifted
// - Lock raised after thousands of reference cycles
// - Startup hold waits for lock
// - Shift done pulses one shift clock period
// - Status bit 0 flags shift overflow
// - Status bit 1 flags reference stopped
// - Status bit 2 sticky synth stopped
// - Status bit 3 flags feedback stopped
// - Long feedback stop drops lock; reset recovers
// - Status on data bus, bits 3-0
// - Status all low while unlocked
// - Access enable answered by ready
// - Reset forces lock, status, clocks low
// - Idle access enable shows status
module cmo_clock_manager #(
  parameter bit                       INPUT_HALVING_OPTION = 1'b0,
  parameter int                       DIVISION_SETTING     = cmo_pkg::DIVISION_DEFAULT,
  parameter int                       SYNTH_MULTIPLIER     = cmo_pkg::SYNTH_MULT_DEFAULT,
  parameter int                       SYNTH_DIVISOR        = cmo_pkg::SYNTH_DIV_DEFAULT,
  parameter bit                       STARTUP_HOLD_OPTION  = 1'b0,
  parameter bit                       FEEDBACK_CONNECTED   = 1'b1,
  parameter bit                       SYNTH_USED           = 1'b1,
  parameter cmo_pkg::cmo_shift_mode_t PHASE_SHIFT_MODE     = cmo_pkg::SHIFT_VAR_CENTER,
  parameter int                       LOCK_CYCLES          = cmo_pkg::LOCK_REF_CYCLES,
  parameter int                       FB_LOSS_CYCLES       = cmo_pkg::FB_LOSS_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        ref_clk_in,
  input  wire logic        feedback_clk_in,
  input  wire logic        shift_clk,
  input  wire logic        shift_request,
  input  wire logic        shift_direction,
  input  wire logic        reconfig_access_enable,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             base_clk_out,
  output logic             quarter_phase_clk_out,
  output logic             half_phase_clk_out,
  output logic             three_quarter_phase_clk_out,
  output logic             doubled_clk_out,
  output logic             doubled_inv_clk_out,
  output logic             divided_clk_out,
  output logic             synth_clk_out,
  output logic             synth_inv_clk_out,
  output logic             locked,
  output logic             config_release,
  output logic             shift_done,
  output logic [15:0]      status_out,
  output logic             reconfig_ready
);
  localparam int PW = cmo_pkg::PERIOD_W;
  localparam logic [31:0] DIV_W = 32'(DIVISION_SETTING);
  localparam logic [31:0] SYN_M = 32'(SYNTH_MULTIPLIER);
  localparam logic [31:0] SYN_D = 32'(SYNTH_DIVISOR);
  localparam logic [15:0] LOCK_N = 16'(LOCK_CYCLES - 1);
  localparam logic [31:0] LOSS_N = 32'(FB_LOSS_CYCLES);

  function automatic logic [31:0] mul32(input logic [31:0] a, input logic [31:0] b);
    mul32 = 32'(a * b);
  endfunction

  logic ref_rise, ref_fall, fb_rise, fb_fall, sclk_rise;
  logic req_s, dir_s, rst, restart_q;
  logic halve_q, eff_rise, ref_stop, fb_stop_raw, syn_stop_raw;
  logic [PW-1:0] phase_q, period_q, half, qtr, pm;
  logic [7:0] div_cnt_q, grp_cnt_q;
  logic [31:0] acc_q, syn_limit, syn_sum, div_pos;
  logic syn_q, syn_prev_q, synth_stop_q, grp_wrap, dbl_d;
  logic [15:0] lock_cnt_q;
  logic [31:0] loss_cnt_q;
  cmo_pkg::cmo_lock_state_t lock_st_q;
  logic is_locked, variable_mode;
  logic signed [9:0] offset_q, lo_lim;
  logic [3:0] step_cnt_q;
  logic busy_q, ovf_q, done_q, ack_q, req;
  logic [31:0] rdata_q;
  logic [15:0] status_d;

  // Soft restart from software resets everything except the input synchronisers and the Avalon slave registers
  assign rst = !reset_n || restart_q;

  cmo_sync u_ref (.core_clk(core_clk), .reset_n(reset_n), .async_in(ref_clk_in),
                  .level_q(), .rise(ref_rise), .fall(ref_fall));
  cmo_sync u_fb (.core_clk(core_clk), .reset_n(reset_n), .async_in(feedback_clk_in),
                 .level_q(), .rise(fb_rise), .fall(fb_fall));
  cmo_sync u_sclk (.core_clk(core_clk), .reset_n(reset_n), .async_in(shift_clk),
                   .level_q(), .rise(sclk_rise), .fall());
  cmo_sync u_req (.core_clk(core_clk), .reset_n(reset_n), .async_in(shift_request),
                  .level_q(req_s), .rise(), .fall());
  cmo_sync u_dir (.core_clk(core_clk), .reset_n(reset_n), .async_in(shift_direction),
                  .level_q(dir_s), .rise(), .fall());

  // Input halving keeps every other reference rise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      halve_q <= 1'b0;
    end else if (ref_rise) begin
      halve_q <= !halve_q;
    end
  end
  assign eff_rise = ref_rise && (!INPUT_HALVING_OPTION || halve_q);

  // Phase counter over one effective reference period; frozen while the reference is stopped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_q  <= '0;
      period_q <= '0;
    end else if (eff_rise) begin
      period_q <= phase_q + 1'b1;
      phase_q  <= '0;
    end else if (!ref_stop && phase_q != '1) begin
      phase_q <= phase_q + 1'b1;
    end
  end

  assign half = period_q >> 1;
  assign qtr  = period_q >> 2;
  assign pm   = (phase_q >= half) ? phase_q - half : phase_q;
  assign div_pos = mul32(32'(div_cnt_q), 32'(period_q)) + 32'(phase_q);
  assign dbl_d = is_locked ? (pm < (half >> 1)) : (phase_q < qtr);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt_q <= 8'h00;
      grp_cnt_q <= 8'h00;
    end else if (eff_rise) begin
      div_cnt_q <= (32'(div_cnt_q) == DIV_W - 1) ? 8'h00 : div_cnt_q + 8'h01;
      grp_cnt_q <= grp_wrap ? 8'h00 : grp_cnt_q + 8'h01;
    end
  end
  assign grp_wrap = (32'(grp_cnt_q) == SYN_D - 1);

  // Clock outputs are registered so they cannot glitch from decode hazards
  always_ff @(posedge core_clk) begin
    if (rst) begin
      base_clk_out                <= 1'b0;
      quarter_phase_clk_out       <= 1'b0;
      half_phase_clk_out          <= 1'b0;
      three_quarter_phase_clk_out <= 1'b0;
      doubled_clk_out             <= 1'b0;
      doubled_inv_clk_out         <= 1'b0;
      divided_clk_out             <= 1'b0;
    end else begin
      base_clk_out                <= phase_q < half;
      quarter_phase_clk_out       <= phase_q >= qtr && phase_q < half + qtr;
      half_phase_clk_out          <= phase_q >= half;
      three_quarter_phase_clk_out <= phase_q < qtr || phase_q >= half + qtr;
      doubled_clk_out             <= dbl_d;
      doubled_inv_clk_out         <= !dbl_d;
      divided_clk_out             <= {div_pos, 1'b0} < {1'b0, mul32(DIV_W, 32'(period_q))};
    end
  end

  // Synthesizer: accumulator toggles every D*P/(2M) core cycles
  assign syn_limit = mul32(SYN_D, 32'(period_q));
  assign syn_sum   = acc_q + {SYN_M[30:0], 1'b0};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_q             <= 32'h0000_0000;
      syn_q             <= 1'b0;
      synth_clk_out     <= 1'b0;
      synth_inv_clk_out <= 1'b0;
    end else begin
      if (!SYNTH_USED || synth_stop_q || syn_limit == 32'h0000_0000) begin
        acc_q <= acc_q; // A stopped synthesizer does not resume until reset
      end else if (eff_rise && grp_wrap) begin
        acc_q <= 32'h0000_0000;
        syn_q <= 1'b1;
      end else if (!ref_stop) begin
        if (syn_sum >= syn_limit) begin
          acc_q <= syn_sum - syn_limit;
          syn_q <= !syn_q;
        end else begin
          acc_q <= syn_sum;
        end
      end
      synth_clk_out     <= syn_q;
      synth_inv_clk_out <= SYNTH_USED && !syn_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      syn_prev_q <= 1'b0;
    end else begin
      syn_prev_q <= syn_q;
    end
  end

  cmo_stop_detect u_ref_stop (.core_clk(core_clk), .clear(rst), .edge_seen(ref_rise | ref_fall),
                              .limit(32'(period_q)), .stopped_q(ref_stop));
  cmo_stop_detect u_fb_stop (.core_clk(core_clk), .clear(rst), .edge_seen(fb_rise | fb_fall),
                             .limit(32'(period_q)), .stopped_q(fb_stop_raw));
  cmo_stop_detect u_syn_stop (.core_clk(core_clk), .clear(rst), .edge_seen(syn_q ^ syn_prev_q),
                              .limit(cmo_pkg::SYNTH_STOP_CYCLES), .stopped_q(syn_stop_raw));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      synth_stop_q <= 1'b0;
    end else if (SYNTH_USED && is_locked && syn_stop_raw) begin
      synth_stop_q <= 1'b1;
    end
  end

  // Lock: count stable effective periods, then watch for a long feedback loss
  assign is_locked = (lock_st_q == cmo_pkg::LK_LOCKED);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_st_q  <= cmo_pkg::LK_ACQUIRE;
      lock_cnt_q <= 16'h0000;
      loss_cnt_q <= 32'h0000_0000;
    end else begin
      case (lock_st_q)
        cmo_pkg::LK_ACQUIRE: begin
          if (eff_rise) begin
            if (phase_q + 1'b1 != period_q || ref_stop) begin
              lock_cnt_q <= 16'h0000;
            end else if (lock_cnt_q == LOCK_N && !(FEEDBACK_CONNECTED && fb_stop_raw)) begin
              lock_st_q <= cmo_pkg::LK_LOCKED;
            end else if (lock_cnt_q != LOCK_N) begin
              lock_cnt_q <= lock_cnt_q + 16'h0001;
            end
          end
        end
        cmo_pkg::LK_LOCKED: begin
          if (FEEDBACK_CONNECTED && fb_stop_raw) begin
            loss_cnt_q <= loss_cnt_q + 32'h0000_0001;
            if (loss_cnt_q == LOSS_N - 1) begin
              lock_st_q <= cmo_pkg::LK_LOST;
            end
          end else begin
            loss_cnt_q <= 32'h0000_0000;
          end
        end
        default: begin
          lock_st_q <= cmo_pkg::LK_LOST; // Only a reset leaves this state
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      locked         <= 1'b0;
      config_release <= 1'b0;
    end else begin
      locked         <= is_locked;
      config_release <= !STARTUP_HOLD_OPTION || is_locked;
    end
  end

  // Variable phase shift, stepped on synchronised shift clock rises
  assign variable_mode = PHASE_SHIFT_MODE == cmo_pkg::SHIFT_VAR_POS
                      || PHASE_SHIFT_MODE == cmo_pkg::SHIFT_VAR_CENTER
                      || PHASE_SHIFT_MODE == cmo_pkg::SHIFT_DIRECT;
  assign lo_lim = (PHASE_SHIFT_MODE == cmo_pkg::SHIFT_VAR_CENTER) ? -cmo_pkg::SHIFT_LIMIT : 10'sh000;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      offset_q   <= 10'sh000;
      step_cnt_q <= 4'h0;
      busy_q     <= 1'b0;
      ovf_q      <= 1'b0;
      done_q     <= 1'b0;
    end else if (variable_mode && sclk_rise) begin
      done_q <= 1'b0;
      if (!busy_q && req_s) begin
        busy_q     <= 1'b1;
        step_cnt_q <= 4'h1;
        if (dir_s && offset_q < cmo_pkg::SHIFT_LIMIT) begin
          offset_q <= offset_q + 10'sh001;
          ovf_q    <= 1'b0;
        end else if (!dir_s && offset_q > lo_lim) begin
          offset_q <= offset_q - 10'sh001;
          ovf_q    <= 1'b0;
        end else begin
          ovf_q <= 1'b1;
        end
      end else if (busy_q) begin
        if (step_cnt_q == cmo_pkg::SHIFT_STEP_CYCLES) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          step_cnt_q <= step_cnt_q + 4'h1;
        end
      end
    end
  end
  assign shift_done = done_q;

  // Status bus and reconfiguration answer
  always_comb begin
    status_d = cmo_pkg::STATUS_RESET;
    status_d[cmo_pkg::ST_OVF] = (PHASE_SHIFT_MODE != cmo_pkg::SHIFT_NONE) && ovf_q;
    status_d[cmo_pkg::ST_REF_STOP] = ref_stop;
    status_d[cmo_pkg::ST_SYNTH_STOP] = synth_stop_q;
    status_d[cmo_pkg::ST_FB_STOP] = FEEDBACK_CONNECTED && fb_stop_raw;
    if (!is_locked || reconfig_access_enable) begin
      status_d = cmo_pkg::STATUS_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_out     <= cmo_pkg::STATUS_RESET;
      reconfig_ready <= 1'b0;
    end else begin
      status_out     <= status_d;
      reconfig_ready <= reconfig_access_enable;
    end
  end

  // Avalon slave: one wait state, then the request completes
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      restart_q <= 1'b0;
    end else begin
      ack_q     <= req && !ack_q;
      restart_q <= avs_write && ack_q && avs_address == cmo_pkg::REG_CTRL
                && avs_byteenable[0] && avs_writedata[cmo_pkg::CTRL_RESTART_BIT];
      if (avs_read && !ack_q) begin
        if (avs_address == cmo_pkg::REG_STATUS) begin
          rdata_q <= {22'h0, lock_st_q == cmo_pkg::LK_LOST, is_locked, 4'h0, status_d[3:0]};
        end else if (avs_address == cmo_pkg::REG_PERIOD) begin
          rdata_q <= {16'h0000, period_q};
        end else if (avs_address == cmo_pkg::REG_SHIFT) begin
          rdata_q <= {{22{offset_q[9]}}, offset_q};
        end else begin
          rdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_unlocked_quiet;
    !is_locked |=> status_out == cmo_pkg::STATUS_RESET;
  endproperty
  a_unlocked_quiet: assert property (p_unlocked_quiet) else $error("status not low");

  property p_upper_zero;
    status_out[15:4] == 12'h000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper status set");

  property p_ready;
    reconfig_access_enable |=> reconfig_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready answer");

  property p_done_one;
    shift_done && sclk_rise |=> !shift_done;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done too long");

  property p_synth_sticky;
    status_out[cmo_pkg::ST_SYNTH_STOP] && is_locked |=> synth_stop_q;
  endproperty
  a_synth_sticky: assert property (p_synth_sticky) else $error("synth stop cleared");

  property p_prelock_dbl;
    !is_locked && eff_rise && !ref_stop && period_q >= 16'h0004 |-> ##2 doubled_clk_out;
  endproperty
  a_prelock_dbl: assert property (p_prelock_dbl) else $error("prelock doubled low");

  property p_base_rise;
    eff_rise && period_q >= 16'h0002 |-> ##2 base_clk_out ##0 !half_phase_clk_out;
  endproperty
  a_base_rise: assert property (p_base_rise) else $error("base not aligned");

  property p_half_inv;
    is_locked && $past(is_locked) |-> half_phase_clk_out == !base_clk_out;
  endproperty
  a_half_inv: assert property (p_half_inv) else $error("half not inverse");

  property p_synth_align;
    SYNTH_USED && !synth_stop_q && eff_rise && grp_wrap && syn_limit != 0 |-> ##2 synth_clk_out;
  endproperty
  a_synth_align: assert property (p_synth_align) else $error("synth not aligned");

  property p_hold;
    STARTUP_HOLD_OPTION && !locked |-> !config_release;
  endproperty
  a_hold: assert property (p_hold) else $error("released before lock");

  property p_ovf_none;
    PHASE_SHIFT_MODE == cmo_pkg::SHIFT_NONE |-> !status_out[cmo_pkg::ST_OVF];
  endproperty
  a_ovf_none: assert property (p_ovf_none) else $error("overflow in none mode");

  c_lock: cover property ($rose(locked));
  c_shift_done: cover property ($rose(shift_done));
  c_ref_stop: cover property ($rose(status_out[cmo_pkg::ST_REF_STOP]));
  c_lost: cover property (lock_st_q == cmo_pkg::LK_LOST);
endmodule

// File: verif/cmo_fabric_model.sv
// Fabric-side model: reference, feedback copy, shift clock and shift requests
module cmo_fabric_model #(
  parameter int REF_HALF = 8
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic base_clk_out,
  input  wire logic ref_run,
  input  wire logic fb_run,
  input  wire logic shift_go,
  input  wire logic shift_dir,
  output logic      ref_clk_in,
  output logic      feedback_clk_in,
  output logic      shift_clk,
  output logic      shift_request,
  output logic      shift_direction
);
  timeunit 1ns;
  timeprecision 1ps;
  int         ref_cnt_q;
  logic [1:0] sck_cnt_q;
  logic       pend_q;
  // A stopped clock holds its level, as a dead oscillator would
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ref_cnt_q <= 0;
      ref_clk_in <= 1'h0;
    end else if (ref_run) begin
      ref_cnt_q <= (ref_cnt_q == REF_HALF - 1) ? 0 : ref_cnt_q + 1;
      if (ref_cnt_q == REF_HALF - 1) ref_clk_in <= !ref_clk_in;
    end
  end
  always_ff @(posedge core_clk) begin
    feedback_clk_in <= fb_run ? base_clk_out : feedback_clk_in;
  end
  // Shift done is never read here; outside variable mode it stays at its reset value of 0
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sck_cnt_q <= 2'h0;
      shift_clk <= 1'h0;
      pend_q <= 1'h0;
      shift_request <= 1'h0;
      shift_direction <= 1'h0;
    end else begin
      sck_cnt_q <= sck_cnt_q + 2'h1;
      if (sck_cnt_q == 2'h3) begin
        shift_clk <= !shift_clk;
        if (!shift_clk) begin
          shift_request <= pend_q;
          shift_direction <= pend_q & shift_dir;
          pend_q <= 1'h0;
        end
      end
      if (shift_go) pend_q <= 1'h1;
    end
  end
endmodule

// File: verif/tb_cmo_clock_manager.sv
// Testbench for the clock manager outputs with a fabric model
module tb_cmo_clock_manager;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, reset_n, ref_clk_in, feedback_clk_in, shift_clk;
  logic        shift_request, shift_direction, ref_run, fb_run, shift_go, shift_dir;
  logic        reconfig_access_enable, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [8:0]  clks, clks_q;
  logic [15:0] status_out;
  logic        locked, shift_done, reconfig_ready, cfg_rel, cnt_en;
  int          cnt[9];
  int          exp_cnt[9] = '{10, 10, 10, 10, 20, 20, 5, 40, 40};
  int          bad, error_cnt, num_checks, n;
  wire  [17:0] obs = {shift_done, locked, status_out};

  cmo_clock_manager #(.LOCK_CYCLES(8), .FB_LOSS_CYCLES(64)) i_cmo_clock_manager (
    .core_clk(core_clk), .reset_n(reset_n), .ref_clk_in(ref_clk_in),
    .feedback_clk_in(feedback_clk_in), .shift_clk(shift_clk), .shift_request(shift_request),
    .shift_direction(shift_direction), .reconfig_access_enable(reconfig_access_enable),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .base_clk_out(clks[0]),
    .quarter_phase_clk_out(clks[1]), .half_phase_clk_out(clks[2]),
    .three_quarter_phase_clk_out(clks[3]), .doubled_clk_out(clks[4]),
    .doubled_inv_clk_out(clks[5]), .divided_clk_out(clks[6]), .synth_clk_out(clks[7]),
    .synth_inv_clk_out(clks[8]), .locked(locked), .config_release(cfg_rel),
    .shift_done(shift_done), .status_out(status_out), .reconfig_ready(reconfig_ready));

  cmo_fabric_model i_cmo_fabric_model (
    .core_clk(core_clk), .reset_n(reset_n), .base_clk_out(clks[0]), .ref_run(ref_run),
    .fb_run(fb_run), .shift_go(shift_go), .shift_dir(shift_dir), .ref_clk_in(ref_clk_in),
    .feedback_clk_in(feedback_clk_in), .shift_clk(shift_clk),
    .shift_request(shift_request), .shift_direction(shift_direction));

  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Rate counts, inverse pairs that ever agree, base rises without a synth rise
  always @(posedge core_clk) begin
    clks_q <= clks;
    for (int i = 0; i < 9; i++) cnt[i] <= !cnt_en ? 0 : cnt[i] + int'(clks[i] & !clks_q[i]);
    if (!cnt_en) bad <= 0;
    else if (clks[2] == clks[0] || clks[3] == clks[1] || clks[5] == clks[4]
             || clks[8] == clks[7] || (clks[0] & !clks_q[0] & !(clks[7] & !clks_q[7])))
      bad <= bad + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0) @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic wait_obs(input int i, input logic v, input int lim, input string m);
    n = 0;
    while (obs[i] !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk(32'(obs[i]), 32'(v), m);
  endtask

  task automatic shift1(input logic dir);
    @(posedge core_clk);
    shift_go <= 1'h1;
    shift_dir <= dir;
    @(posedge core_clk);
    shift_go <= 1'h0;
    wait_obs(17, 1'h1, 200, "shift done");
    n = 0;
    while (shift_done === 1'h1) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    $display("mismatch at %0t: timeout", $time);
    finish_test;
  end

  initial begin
    {reset_n, fb_run, shift_go, shift_dir, avs_read, avs_write, cnt_en} = '0;
    {avs_address, avs_writedata, reconfig_access_enable, error_cnt, num_checks} = '0;
    ref_run = 1'h1;
    fb_run = 1'h1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk({locked, status_out}, 17'h0, "reset outputs");
    @(posedge core_clk);
    reset_n <= 1'h1;
    wait_obs(16, 1'h1, 3000, "lock");
    chk(status_out, 16'h0, "status after lock");
    chk(32'(cfg_rel), 1, "config release");
    bus(1'h0, cmo_pkg::REG_STATUS, 0);
    chk(rd, 32'h0000_0100, "status reg");
    bus(1'h0, cmo_pkg::REG_PERIOD, 0);
    chk(rd, 32'h0000_0010, "period reg");
    bus(1'h0, 4'h2, 0);
    chk(rd, 32'h0, "unmapped read");
    $display("test lock done");
    @(posedge core_clk);
    cnt_en <= 1'h1;
    repeat (160) @(posedge core_clk);
    cnt_en <= 1'h0;
    @(negedge core_clk);
    for (int i = 0; i < 9; i++)
      chk(32'(cnt[i] >= exp_cnt[i] - 1 && cnt[i] <= exp_cnt[i] + 1), 1, "rate");
    chk(bad, 0, "phase");
    $display("test clocks done");
    shift1(1'h1);
    chk(n, 8, "done width");
    for (int i = 0; i < 255; i++) shift1(1'h1);
    chk(32'(status_out[0]), 1, "overflow");
    // Overflow is set here, so the status bus has something to hide during access
    @(posedge core_clk);
    reconfig_access_enable <= 1'h1;
    @(posedge core_clk);
    reconfig_access_enable <= 1'h0;
    @(negedge core_clk);
    chk({reconfig_ready, status_out}, 17'h10000, "reconfig answer");
    @(negedge core_clk);
    chk({reconfig_ready, status_out}, 17'h00001, "ready drop");
    $display("test reconfig done");
    shift1(1'h0);
    bus(1'h0, cmo_pkg::REG_SHIFT, 0);
    chk(rd, 32'h0000_00FE, "offset");
    $display("test shift done");
    @(posedge core_clk);
    fb_run <= 1'h0;
    wait_obs(3, 1'h1, 96, "feedback stop");
    @(posedge core_clk);
    fb_run <= 1'h1;
    wait_obs(3, 1'h0, 96, "feedback back");
    chk(32'(locked), 1, "lock kept");
    @(posedge core_clk);
    ref_run <= 1'h0;
    wait_obs(1, 1'h1, 144, "ref stop");
    wait_obs(16, 1'h0, 200, "lock lost");
    chk(status_out, 16'h0, "status unlocked");
    bus(1'h0, cmo_pkg::REG_STATUS, 0);
    chk(rd, 32'h0000_0200, "lost flag");
    ref_run <= 1'h1;
    bus(1'h1, cmo_pkg::REG_CTRL, 32'h1);
    wait_obs(16, 1'h1, 3000, "relock");
    chk(status_out, 16'h0, "status cleared");
    $display("test stop done");
    finish_test;
  end
endmodule
